// ---- logic/iocot_core.sv ----
// Termination core of an I/O channel: begin-I/O, chaining, data-transfer end, interruptions.
// Assumes all inputs are synchronous to i_clk_sys and events are one-cycle pulses.
`timescale 1ns/1ns
module iocot_core
  import iocot_pkg::*;
#(
  parameter int NSUB = `IOCOT_NSUB,
  parameter int CNT_W = `IOCOT_CNT_W
)
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Program side: begin-I/O and interruption handling.
  input wire logic i_begin_io,
  input wire logic [$clog2(NSUB)-1:0] i_sub_sel,
  input wire logic i_prog_err,
  input wire logic i_intr_take,
  input wire logic i_probe_io,
  input wire logic i_stop_io,
  input wire logic i_selector,
  input wire logic i_burst,
  // Command word presented for the current initiation.
  input wire logic i_cmd_chain,
  input wire logic i_cmd_sli,
  input wire logic [CNT_W-1:0] i_cmd_count,
  input wire logic i_addr_bad,
  // Chaining: next command word fetched, or fetch errors.
  input wire logic i_chain_valid,
  input wire logic i_chain_err,
  input wire logic i_prot_err,
  input wire logic i_chck_err,
  // Device side.
  input wire logic i_dev_answer,
  input wire logic [`IOCOT_ST_W-1:0] i_dev_status,
  input wire logic i_dev_notop,
  input wire logic i_dev_end,
  input wire logic i_svc_req,
  input wire logic i_malfunction,
  // Program results.
  output logic o_bio_done,
  output logic [1:0] o_cond_code,
  output logic o_csw_stored,
  output logic [`IOCOT_ST_W-1:0] o_csw_dev,
  output logic [`IOCOT_ST_W-1:0] o_csw_chan,
  output logic [CNT_W-1:0] o_csw_count,
  output logic o_intr_req,
  // Device commands.
  output logic o_svc_ack,
  output logic o_svc_stop,
  output logic o_disconnect,
  output logic o_dev_start,
  // State views.
  output logic o_chan_working,
  output logic [NSUB-1:0] o_sub_working
);
  typedef enum logic [2:0] {C_IDLE, C_INIT, C_XFER, C_WAITDE} iocot_ph_t;
  localparam int SW = $clog2(NSUB);

  // Unusual device status: unit check or unit exception.
  function automatic logic unusual(input logic [`IOCOT_ST_W-1:0] s);
    unusual = s[`IOCOT_DS_UC] | s[`IOCOT_DS_UE];
  endfunction

  iocot_ph_t ph_r;
  logic [SW-1:0] sub_r;
  logic first_r;
  logic chain_r;
  logic sli_r;
  logic imm_r;
  logic stop_r;
  logic addr_bad_r;
  logic [CNT_W-1:0] cnt_r;
  logic [`IOCOT_ST_W-1:0] cs_r;
  logic [`IOCOT_ST_W-1:0] cs_nxt;
  iocot_sub_t st [NSUB];
  logic [NSUB-1:0] ev_start, ev_pend, ev_devb, ev_free, ev_clear;
  logic ans_ce, ans_zero, ans_rej, ans_imm, fin_ce, chk_err, abort;
  logic pend_any;

  assign ans_ce = i_dev_status[`IOCOT_DS_CE];
  assign ans_zero = (i_dev_status == '0) && !i_dev_notop;
  assign ans_rej = i_dev_answer && !ans_imm && !ans_zero;
  // A dead device never counts as an immediate end, whatever its status lines show.
  assign ans_imm = i_dev_answer && ans_ce && !i_dev_notop;
  assign chk_err = i_chain_err | i_prot_err | i_chck_err;
  assign abort = i_malfunction || (i_stop_io && i_selector);
  // end taken in any cycle of transfer
  assign fin_ce = (ph_r == C_XFER) && i_dev_end && i_dev_status[`IOCOT_DS_CE];

  // Per-subchannel state machines.
  genvar g;
  generate
    for (g = 0; g < NSUB; g++)
    begin : g_sub
      iocot_sub u_sub (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_start(ev_start[g]),
        .i_to_pend(ev_pend[g]),
        .i_to_devbusy(ev_devb[g]),
        .i_free(ev_free[g]),
        .i_clear(ev_clear[g]),
        .o_state(st[g])
      );
    end
  endgenerate

  // Events routed to the current or selected subchannel, or to all on interruption take.
  always_comb
  begin
    ev_start = '0;
    ev_pend = '0;
    ev_devb = '0;
    ev_free = '0;
    ev_clear = '0;
    pend_any = 1'b0;
    for (int k = 0; k < NSUB; k++)
    begin
      if (st[k] == IOCOT_PEND)
      begin
        pend_any = 1'b1;
      end
    end
    for (int k = 0; k < NSUB; k++)
    begin
      ev_clear[k] = i_intr_take || (i_probe_io && i_sub_sel == SW'(k));
    end
    // Accepted begin-I/O marks the subchannel working before the answer can free it.
    if (ph_r == C_IDLE && i_begin_io && !i_prog_err && st[i_sub_sel] == IOCOT_AVAIL && !abort)
    begin
      ev_start[i_sub_sel] = 1'b1;
    end
    if (ph_r == C_INIT && i_dev_answer)
    begin
      if (ans_rej && first_r)
      begin
        ev_free[sub_r] = 1'b1;
      end
      if ((ans_rej || chk_err) && !first_r)
      begin
        ev_pend[sub_r] = 1'b1;
      end
      // first immediate frees or leaves device busy
      if (ans_imm && first_r && !chain_r)
      begin
        if (i_dev_status[`IOCOT_DS_DE])
        begin
          ev_free[sub_r] = 1'b1;
        end
        else
        begin
          ev_devb[sub_r] = 1'b1;
        end
      end
      // chained immediate at end of chain
      if (ans_imm && !first_r && (!chain_r || unusual(i_dev_status)))
      begin
        ev_pend[sub_r] = 1'b1;
      end
    end
    if (fin_ce && (!chain_r || cs_r != '0 || unusual(i_dev_status)))
    begin
      ev_pend[sub_r] = 1'b1;
    end
    // fault with later end goes pending
    if ((ph_r == C_XFER || ph_r == C_WAITDE) && i_dev_end && unusual(i_dev_status)
        && (i_dev_status[`IOCOT_DS_CUE] || i_dev_status[`IOCOT_DS_DE]))
    begin
      ev_pend[sub_r] = 1'b1;
    end
    for (int k = 0; k < NSUB; k++)
    begin
      if (st[k] == IOCOT_DEVBUSY && i_dev_end && i_dev_status[`IOCOT_DS_DE]
          && i_sub_sel == SW'(k))
      begin
        ev_pend[k] = 1'b1;
      end
    end
    if (abort && ph_r != C_IDLE)
    begin
      ev_pend[sub_r] = 1'b1;
    end
  end

  // Channel status accumulation, updated in every cycle.
  // status in same cycle
  always_comb
  begin
    cs_nxt = cs_r;
    cs_nxt[`IOCOT_CS_PRG] = cs_r[`IOCOT_CS_PRG] | i_chain_err;
    cs_nxt[`IOCOT_CS_PROT] = cs_r[`IOCOT_CS_PROT] | i_prot_err;
    cs_nxt[`IOCOT_CS_CHC] = cs_r[`IOCOT_CS_CHC] | i_chck_err;
    cs_nxt[`IOCOT_CS_CCC] = cs_r[`IOCOT_CS_CCC] | i_malfunction;
    // chained not operational as interface check
    cs_nxt[`IOCOT_CS_ICC] = cs_r[`IOCOT_CS_ICC]
      | (ph_r == C_INIT && i_dev_answer && i_dev_notop && !first_r);
    cs_nxt[`IOCOT_CS_IL] = cs_r[`IOCOT_CS_IL]
      | (fin_ce && !imm_r && !sli_r && cnt_r != '0);
  end

  // Phase of the operation.
  // stays in transfer until end
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ph_r <= C_IDLE;
    end
    else if (abort)
    begin
      ph_r <= C_IDLE;
    end
    else
    begin
      case (ph_r)
        C_IDLE:
        begin
          if (i_begin_io && !i_prog_err && st[i_sub_sel] == IOCOT_AVAIL)
          begin
            ph_r <= C_INIT;
          end
        end
        C_INIT:
        begin
          if (ans_rej || chk_err)
          begin
            ph_r <= C_IDLE;
          end
          else if (ans_imm)
          begin
            ph_r <= (chain_r && !unusual(i_dev_status)) ? C_WAITDE : C_IDLE;
          end
          else if (i_dev_answer)
          begin
            ph_r <= C_XFER;
          end
        end
        C_XFER:
        begin
          if (i_dev_end && unusual(i_dev_status))
          begin
            ph_r <= C_IDLE;
          end
          else if (fin_ce)
          begin
            ph_r <= (chain_r && cs_r == '0) ? C_WAITDE : C_IDLE;
          end
        end
        C_WAITDE:
        begin
          if (chk_err || (i_dev_end && unusual(i_dev_status)))
          begin
            ph_r <= C_IDLE;
          end
          else if (i_chain_valid)
          begin
            ph_r <= C_INIT;
          end
        end
        default:
        begin
          ph_r <= C_IDLE;
        end
      endcase
    end
  end

  // Operation context: subchannel, command flags, count, chain position.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sub_r <= '0;
      first_r <= 1'b0;
      chain_r <= 1'b0;
      sli_r <= 1'b0;
      imm_r <= 1'b0;
      addr_bad_r <= 1'b0;
      cnt_r <= '0;
      cs_r <= '0;
    end
    else if (ph_r == C_IDLE && i_begin_io)
    begin
      sub_r <= i_sub_sel;
      first_r <= 1'b1;
      chain_r <= i_cmd_chain;
      sli_r <= i_cmd_sli;
      imm_r <= 1'b0;
      addr_bad_r <= i_addr_bad;
      cnt_r <= i_cmd_count;
      cs_r <= '0;
    end
    else
    begin
      cs_r <= cs_nxt;
      if (ph_r == C_INIT && ans_imm)
      begin
        imm_r <= 1'b1;
        addr_bad_r <= 1'b0;
      end
      if (ph_r == C_WAITDE && i_chain_valid)
      begin
        first_r <= 1'b0;
        chain_r <= i_cmd_chain;
        sli_r <= i_cmd_sli;
        imm_r <= 1'b0;
        addr_bad_r <= i_addr_bad;
        cnt_r <= i_cmd_count;
      end
      if (ph_r == C_XFER && i_svc_req && !stop_r && !addr_bad_r && cnt_r != '0)
      begin
        cnt_r <= cnt_r - CNT_W'(1);
      end
    end
  end

  // Stop indication pending for the next service request.
  // stop on zero count or check
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      stop_r <= 1'b0;
    end
    else if (ph_r != C_XFER)
    begin
      stop_r <= 1'b0;
    end
    else if (addr_bad_r || chk_err || (cnt_r == '0 && !chain_r))
    begin
      stop_r <= 1'b1;
    end
  end

  // Service-request replies: data accept or stop.
  // stop is the reply
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_svc_ack <= 1'b0;
      o_svc_stop <= 1'b0;
    end
    else
    begin
      o_svc_ack <= (ph_r == C_XFER) && i_svc_req && !stop_r && !addr_bad_r && cnt_r != '0;
      o_svc_stop <= (ph_r == C_XFER) && i_svc_req && (stop_r || addr_bad_r || cnt_r == '0);
    end
  end

  // Begin-I/O result: condition code and stored status.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bio_done <= 1'b0;
      o_cond_code <= `IOCOT_CC_OK;
      o_csw_stored <= 1'b0;
      o_csw_dev <= '0;
      o_csw_chan <= '0;
      o_csw_count <= '0;
    end
    else
    begin
      o_bio_done <= 1'b0;
      o_csw_stored <= 1'b0;
      if (ph_r == C_IDLE && i_begin_io && (i_prog_err || st[i_sub_sel] != IOCOT_AVAIL))
      begin
        o_bio_done <= 1'b1;
        o_cond_code <= i_prog_err ? `IOCOT_CC_STORED : `IOCOT_CC_BUSY;
        o_csw_stored <= i_prog_err;
        o_csw_chan <= i_prog_err ? (`IOCOT_ST_W'(1) << `IOCOT_CS_PRG) : '0;
        o_csw_dev <= '0;
      end
      else if (ph_r == C_INIT && first_r && i_dev_answer)
      begin
        o_bio_done <= 1'b1;
        if (i_dev_notop)
        begin
          o_cond_code <= `IOCOT_CC_NOTOP;
        end
        else if (ans_rej || (ans_imm && !chain_r))
        begin
          o_cond_code <= `IOCOT_CC_STORED;
          o_csw_stored <= 1'b1;
          o_csw_dev <= i_dev_status;
          o_csw_chan <= cs_nxt;
        end
        else
        begin
          o_cond_code <= `IOCOT_CC_OK;
        end
      end
      else if (|ev_pend)
      begin
        o_csw_dev <= i_dev_status;
        o_csw_chan <= cs_nxt;
        o_csw_count <= cnt_r;
      end
    end
  end

  // Device commands and working views.
  // chain keeps selector channel working
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_disconnect <= 1'b0;
      o_dev_start <= 1'b0;
      o_intr_req <= 1'b0;
      o_chan_working <= 1'b0;
      o_sub_working <= '0;
    end
    else
    begin
      o_disconnect <= abort && ph_r != C_IDLE;
      o_dev_start <= ph_r == C_INIT && i_dev_answer && ans_zero && !chk_err;
      o_intr_req <= pend_any;
      o_chan_working <= (ph_r != C_IDLE) && (i_selector || (i_burst && ph_r == C_XFER));
      for (int k = 0; k < NSUB; k++)
      begin
        o_sub_working[k] <= st[k] == IOCOT_WORK;
      end
    end
  end

  // Checks.
  stop_reply_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (ph_r == C_XFER && i_svc_req && addr_bad_r) |=> o_svc_stop && !o_svc_ack)
    else $error("stop not given on bad address");
  code_three_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (ph_r == C_INIT && first_r && i_dev_answer && i_dev_notop)
    |=> o_cond_code == `IOCOT_CC_NOTOP && !o_csw_stored)
    else $error("not operational code wrong");
  reject_free_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (ph_r == C_INIT && first_r && ans_rej && !abort) |=> st[sub_r] == IOCOT_AVAIL)
    else $error("rejected subchannel not freed");
  chain_rej_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (ph_r == C_INIT && !first_r && ans_rej) |=> st[$past(sub_r)] == IOCOT_PEND)
    else $error("chained reject not pending");
  // Operation ends, then the interruption request rises one cycle later.
  sequence end_intr_s;
    ph_r == C_IDLE ##1 o_intr_req;
  endsequence
  final_end_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (fin_ce && !chain_r && !abort) |=> end_intr_s)
    else $error("final end without interruption");
  abort_disc_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_malfunction && ph_r != C_IDLE) |=> o_disconnect && ph_r == C_IDLE)
    else $error("malfunction did not disconnect");
  no_data_imm_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (ph_r == C_INIT && ans_imm) |=> !o_svc_ack)
    else $error("immediate moved data");
  start_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_dev_start |-> $past(ph_r) == C_INIT && $past(i_dev_status) == '0)
    else $error("started on nonzero status");
endmodule

// ---- logic/iocot_params.svh ----
// Timing-free constants of the channel termination block: status bit positions and codes.
// Assumes inclusion by bare name from the package and the modules.
`ifndef IOCOT_PARAMS_SVH
`define IOCOT_PARAMS_SVH
`define IOCOT_NSUB 4
`define IOCOT_CNT_W 16
`define IOCOT_ST_W 8
`define IOCOT_DS_ATTN 7
`define IOCOT_DS_SM 6
`define IOCOT_DS_CUE 5
`define IOCOT_DS_BUSY 4
`define IOCOT_DS_CE 3
`define IOCOT_DS_DE 2
`define IOCOT_DS_UC 1
`define IOCOT_DS_UE 0
`define IOCOT_CS_PCI 7
`define IOCOT_CS_IL 6
`define IOCOT_CS_PRG 5
`define IOCOT_CS_PROT 4
`define IOCOT_CS_CDC 3
`define IOCOT_CS_CCC 2
`define IOCOT_CS_ICC 1
`define IOCOT_CS_CHC 0
`define IOCOT_CC_OK 2'h0
`define IOCOT_CC_STORED 2'h1
`define IOCOT_CC_BUSY 2'h2
`define IOCOT_CC_NOTOP 2'h3
`endif

// ---- logic/iocot_pkg.sv ----
// Types shared by the channel termination block.
// Assumes the constants header is on the include path.
`include "iocot_params.svh"
package iocot_pkg;
  typedef enum logic [1:0] {IOCOT_AVAIL, IOCOT_WORK, IOCOT_PEND, IOCOT_DEVBUSY} iocot_sub_t;
  typedef logic [`IOCOT_ST_W-1:0] iocot_stat_t;
endpackage

// ---- logic/iocot_sub.sv ----
// One subchannel state machine: available, working, interruption pending, device busy.
// Assumes one-cycle event pulses from the termination core on a single clock.
`timescale 1ns/1ns
module iocot_sub
  import iocot_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Events from the core.
  input wire logic i_start,
  input wire logic i_to_pend,
  input wire logic i_to_devbusy,
  input wire logic i_free,
  input wire logic i_clear,
  // State.
  output iocot_sub_t o_state
);
  iocot_sub_t state_r;
  assign o_state = state_r;

  // Next state; a new pending event wins over a clear in the same cycle.
  // per-subchannel state
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= IOCOT_AVAIL;
    end
    else if (i_to_pend)
    begin
      state_r <= IOCOT_PEND;
    end
    else if (i_to_devbusy)
    begin
      state_r <= IOCOT_DEVBUSY;
    end
    else if (i_start)
    begin
      state_r <= IOCOT_WORK;
    end
    else if (i_free || (i_clear && state_r == IOCOT_PEND))
    begin
      state_r <= IOCOT_AVAIL;
    end
  end
endmodule

// ---- verif/io_channel_operation_termination_bench.sv ----
// Self-checking bench of the channel termination core with a device model.
// Assumes the package and the constants header are compiled first.
`timescale 1ns/1ns
`include "iocot_params.svh"
module io_channel_operation_termination_bench import iocot_pkg::*;;
  // Stimulus and interface signals.
  logic i_clk_sys, i_rst_n, i_begin_io, i_prog_err, i_intr_take, i_probe_io, i_stop_io;
  logic i_selector, i_burst, i_cmd_chain, i_cmd_sli, i_addr_bad, i_chain_valid;
  logic i_chain_err, i_prot_err, i_chck_err, i_malfunction, i_dev_answer, i_dev_notop;
  logic i_dev_end, i_svc_req, o_bio_done, o_csw_stored, o_intr_req, o_svc_ack, o_svc_stop;
  logic o_disconnect, o_dev_start, o_chan_working, ans_notop, seen;
  logic [1:0] i_sub_sel, o_cond_code, sel;
  logic [15:0] i_cmd_count, o_csw_count;
  logic [3:0] o_sub_working;
  iocot_stat_t i_dev_status, o_csw_dev, o_csw_chan, ans_status;
  int seed = 92;
  int miscompares, num_checks, cycles, acks, n, c, k;

  // Clock of 100 ns period.
  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  // Cuts a hung run short.
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      $display("MISMATCH t=%0t cycles=%h limit=%h", $time, cycles, 5000);
      end_of_test();
    end
  end

  // Design and partner.
  iocot_core #(.NSUB(4), .CNT_W(16)) u_dut (.i_clk_sys, .i_rst_n, .i_begin_io, .i_sub_sel,
    .i_prog_err, .i_intr_take, .i_probe_io, .i_stop_io, .i_selector, .i_burst, .i_cmd_chain,
    .i_cmd_sli, .i_cmd_count, .i_addr_bad, .i_chain_valid, .i_chain_err, .i_prot_err,
    .i_chck_err, .i_dev_answer, .i_dev_status, .i_dev_notop, .i_dev_end, .i_svc_req,
    .i_malfunction, .o_bio_done, .o_cond_code, .o_csw_stored, .o_csw_dev, .o_csw_chan,
    .o_csw_count, .o_intr_req, .o_svc_ack, .o_svc_stop, .o_disconnect, .o_dev_start,
    .o_chan_working, .o_sub_working);
  iocot_dev_model u_dev (.i_clk_sys, .i_rst_n, .i_begin_io, .i_chain_valid,
    .i_svc_ack(o_svc_ack), .i_svc_stop(o_svc_stop), .i_ans_status(ans_status),
    .i_ans_notop(ans_notop), .o_dev_answer(i_dev_answer), .o_dev_status(i_dev_status),
    .o_dev_notop(i_dev_notop), .o_dev_end(i_dev_end), .o_svc_req(i_svc_req));

  // Expected results worked out per scenario.
  function automatic int exp_acks(input int cause, input int cnt);
    return (cause == 0) ? cnt : 0;
  endfunction
  function automatic int chan_bit(input int cause);
    return (cause == 2) ? `IOCOT_CS_PRG : (cause == 3) ? `IOCOT_CS_PROT : `IOCOT_CS_CHC;
  endfunction
  function automatic logic [1:0] exp_cc(input int kind);
    return (kind == 1) ? `IOCOT_CC_NOTOP : `IOCOT_CC_STORED;
  endfunction

  // Clock steps, comparisons and the closing report.
  task tick(input int cnt);
    repeat (cnt) @(posedge i_clk_sys);
    #2;
  endtask
  task chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Program-side operations.
  task start_op(input logic [1:0] s, input int cnt, input logic ch, input logic bad,
                input logic perr);
    {i_sub_sel, i_cmd_chain, i_addr_bad, i_prog_err} = {s, ch, bad, perr};
    i_cmd_count = 16'(cnt);
    i_cmd_sli = 1'($random(seed));
    i_begin_io = 1'b1;
    tick(1);
    {i_begin_io, i_prog_err} = 2'h0;
  endtask
  task wait_bio;
    int w;
    w = 0;
    while (o_bio_done !== 1'b1 && w < 20)
    begin
      tick(1);
      w++;
    end
    if (w == 20)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, o_bio_done, 1'b1);
    end
  endtask
  task wait_flag(input int cnt, input logic intr);
    seen = 1'b0;
    repeat (cnt)
    begin
      seen = seen | ((intr ? o_intr_req : o_disconnect) === 1'b1);
      tick(1);
    end
  endtask
  task clear(input logic probe, input logic [1:0] s);
    {i_probe_io, i_intr_take, i_sub_sel} = {probe, ~probe, s};
    tick(1);
    {i_probe_io, i_intr_take} = 2'h0;
    tick(2);
  endtask

  // Main sequence.
  initial
  begin
    {i_begin_io, i_prog_err, i_intr_take, i_probe_io, i_stop_io, i_burst, i_cmd_chain} = 7'h00;
    {i_cmd_sli, i_addr_bad, i_chain_valid, i_chain_err, i_prot_err, i_chck_err} = 6'h00;
    {i_malfunction, i_sub_sel, i_cmd_count, ans_notop, ans_status} = 28'h0000000;
    {i_selector, i_rst_n} = 2'h2;
    tick(4);
    i_rst_n = 1'b1;
    chk_bit(o_intr_req, 1'b0);
    chk_val(16'(o_sub_working), 16'h0000);
    // Each cause of ending a transfer: count, bad address, checks, early end.
    for (c = 0; c < 6; c++)
    begin
      sel = 2'($random(seed));
      n = 1 + ($unsigned($random(seed)) % 6);
      start_op(sel, n, 1'b0, c == 1, 1'b0);
      wait_bio();
      chk_val(16'(o_cond_code), 16'h0000);
      chk_bit(o_dev_start, 1'b1);
      chk_bit(o_chan_working, 1'b1);
      chk_bit(o_sub_working[sel], 1'b1);
      {i_chain_err, i_prot_err, i_chck_err} = {c == 2, c == 3, c == 4};
      tick(1);
      {i_chain_err, i_prot_err, i_chck_err} = 3'h0;
      u_dev.run_xfer((c == 0) ? n + 2 : (c == 5) ? 0 : 3, 8'h0C, acks);
      chk_val(16'(acks), 16'(exp_acks(c, n)));
      wait_flag(10, 1'b1);
      chk_bit(seen, 1'b1);
      chk_bit(o_csw_dev[`IOCOT_DS_CE], 1'b1);
      if (c == 0) chk_val(o_csw_count, 16'h0000);
      if (c >= 2 && c <= 4) chk_bit(o_csw_chan[chan_bit(c)], 1'b1);
      clear(c[0], sel);
      chk_bit(o_intr_req, 1'b0);
      $display("test stop cause %0d done", c);
    end
    // Rejection at begin-I/O: program error, not operational, busy, unit check.
    for (k = 0; k < 4; k++)
    begin
      ans_status = (k == 2) ? 8'h10 : (k == 3) ? 8'h02 : 8'h00;
      ans_notop = (k == 1);
      start_op(sel, 4, 1'b0, 1'b0, k == 0);
      wait_bio();
      chk_val(16'(o_cond_code), 16'(exp_cc(k)));
      chk_bit(o_dev_start, 1'b0);
      tick(4);
      chk_bit(o_intr_req, 1'b0);
      chk_bit(o_sub_working[sel], 1'b0);
    end
    ans_notop = 1'b0;
    $display("test reject done");
    // Immediate operations, with and without the later unit-fully-done.
    ans_status = 8'h0C;
    start_op(sel, 5, 1'b0, 1'b1, 1'b0);
    wait_bio();
    chk_val(16'(o_cond_code), 16'(`IOCOT_CC_STORED));
    chk_bit(o_csw_dev[`IOCOT_DS_CE], 1'b1);
    chk_bit(o_csw_chan[`IOCOT_CS_IL], 1'b0);
    chk_bit(o_csw_chan[`IOCOT_CS_PRG], 1'b0);
    tick(4);
    chk_bit(o_intr_req, 1'b0);
    ans_status = 8'h08;
    start_op(sel, 2, 1'b0, 1'b0, 1'b0);
    wait_bio();
    chk_val(16'(o_cond_code), 16'(`IOCOT_CC_STORED));
    tick(3);
    chk_bit(o_intr_req, 1'b0);
    // The device is still busy, so a new begin-I/O to it finds the subchannel busy.
    start_op(sel, 2, 1'b0, 1'b0, 1'b0);
    wait_bio();
    chk_val(16'(o_cond_code), 16'(`IOCOT_CC_BUSY));
    tick(3);
    u_dev.send_end(8'h04);
    wait_flag(6, 1'b1);
    chk_bit(seen, 1'b1);
    clear(1'b0, sel);
    $display("test immediate done");
    // Chain after an immediate, then a chained command to a dead device.
    ans_status = 8'h0C;
    start_op(sel, 3, 1'b1, 1'b0, 1'b0);
    wait_bio();
    chk_bit(o_csw_stored, 1'b0);
    chk_bit(o_sub_working[sel], 1'b1);
    ans_status = 8'h00;
    {ans_notop, i_cmd_chain, i_chain_valid} = 3'h5;
    tick(1);
    i_chain_valid = 1'b0;
    wait_flag(10, 1'b1);
    chk_bit(seen, 1'b1);
    chk_bit(o_csw_chan[`IOCOT_CS_ICC], 1'b1);
    clear(1'b0, sel);
    ans_notop = 1'b0;
    $display("test chain done");
    // Forced disconnect: malfunction in burst mode, then stop-I/O on the selector channel.
    ans_status = 8'h00;
    for (k = 0; k < 2; k++)
    begin
      {i_selector, i_burst} = {k[0], ~k[0]};
      start_op(sel, 4, 1'b0, 1'b0, 1'b0);
      wait_bio();
      chk_bit(o_chan_working, k[0]);
      {i_malfunction, i_stop_io} = {~k[0], k[0]};
      tick(1);
      {i_malfunction, i_stop_io} = 2'h0;
      chk_bit(o_chan_working, 1'b1);
      wait_flag(5, 1'b0);
      chk_bit(seen, 1'b1);
      chk_bit(o_sub_working[sel], 1'b0);
      clear(1'b0, sel);
    end
    $display("test disconnect done");
    end_of_test();
  end
endmodule

// ---- verif/iocot_dev_model.sv ----
// Behavioural control unit and device on the channel interface.
// Assumes the bench calls the tasks from one process, just after clock edges.
`timescale 1ns/1ns
module iocot_dev_model
  import iocot_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Channel requests and replies.
  input wire logic i_begin_io,
  input wire logic i_chain_valid,
  input wire logic i_svc_ack,
  input wire logic i_svc_stop,
  // Answer chosen by the bench.
  input wire iocot_stat_t i_ans_status,
  input wire logic i_ans_notop,
  // Device lines.
  output logic o_dev_answer,
  output iocot_stat_t o_dev_status,
  output logic o_dev_notop,
  output logic o_dev_end,
  output logic o_svc_req
);
  // Strobes idle low; the status lines start at an arbitrary pattern.
  initial
  begin
    {o_dev_answer, o_dev_notop, o_dev_end, o_svc_req} = 4'h0;
    o_dev_status = 8'hA5;
  end

  // Initiation answer status
  // Answer one cycle after the channel takes the request, then show the inverse
  // on the status lines so that a stale value never looks valid.
  always @(posedge i_clk_sys)
  begin
    if (i_rst_n && (i_begin_io || i_chain_valid))
    begin
      @(posedge i_clk_sys);
      #2;
      {o_dev_answer, o_dev_status, o_dev_notop} = {1'b1, i_ans_status, i_ans_notop};
      @(posedge i_clk_sys);
      #2;
      {o_dev_answer, o_dev_status, o_dev_notop} = {1'b0, ~i_ans_status, ~i_ans_notop};
    end
  end

  // Ending status given
  // Presents ending status for one cycle, then drops the end strobe and shows the inverse status.
  task send_end(input iocot_stat_t st);
    @(posedge i_clk_sys);
    #2;
    {o_dev_end, o_dev_status} = {1'b1, st};
    @(posedge i_clk_sys);
    #2;
    {o_dev_end, o_dev_status} = {1'b0, ~st};
  endtask

  // Requests until stopped
  // Issues service requests; the reply comes the cycle after each request.
  task run_xfer(input int max_req, input iocot_stat_t end_st, output int acks);
    logic stopped;
    acks = 0;
    stopped = 1'b0;
    for (int i = 0; i < max_req && !stopped; i++)
    begin
      @(posedge i_clk_sys);
      #2;
      o_svc_req = 1'b1;
      @(posedge i_clk_sys);
      #2;
      o_svc_req = 1'b0;
      if (i_svc_stop === 1'b1)
        stopped = 1'b1;
      else if (i_svc_ack === 1'b1)
        acks++;
    end
    send_end(end_st);
  endtask
endmodule
